// ==== shared/gsr_pkg.sv ====
// Shared constants and types for the instrument status reporting block.
package gsr_pkg;
  // Standard event register bit positions.
  localparam int EVT_OPC = 0;
  localparam int EVT_ALM = 3;
  localparam int EVT_EXE = 4;
  localparam int EVT_CME = 5;
  localparam int EVT_PON = 7;
  // Status byte bit positions.
  localparam int STB_TMO = 0;
  localparam int STB_INTERNAL_BUS_ERROR_BIT = 1;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  // Reset values.
  localparam logic [7:0] EVT_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  // Bus message codes.
  typedef enum logic [3:0] {
    MSG_NONE, MSG_DCL, MSG_SPE, MSG_SPD, MSG_LLO, MSG_UNL, MSG_UNT,
    MSG_SDC, MSG_GTL, MSG_GET, MSG_PPU, MSG_PPC, MSG_TCT, MSG_LISTEN, MSG_TALK
  } gsr_msg_t;
  // Parsed command strobes from the command interpreter.
  typedef struct packed {
    logic cmdError;
    logic execError;
    logic alarm;
    logic opComplete;
    logic clearStatus;
    logic resetCmd;
    logic writeEnable;
    logic writeSre;
    logic readEvents;
  } gsr_cmd_t;
  // Panel key permission outputs.
  typedef struct packed {
    logic otherKeys;
    logic localKey;
  } gsr_keys_t;
endpackage

// ==== src/gsr_status_reporting.sv ====
// Status byte, standard event register and remote/local state of an instrument.
`timescale 1ns/10ps
// Summary of operation
// - Execution error sets event bit 4.
// - Command error sets event bit 5.
// - Enable mask 0..255, one unmasks.
// - Enable mask zero at power-up, kept until written or reset.
// - Event query returns then clears register.
// - Event summary is masked event OR.
// - Master summary and service request from enable.
// - Status bits message, bus error, timeout.
// - Service request only on the GPIB.
// - Status query shows master summary, clears nothing.
// - Poll shows request bit, clears only it.
// - Status byte has no direct clear.
// - Clear-status clears events, keeps queue.
// - Message bit falls when queue empty.
// - Master summary falls when causes clear.
// - Interface clear drops addressing only.
// - Device clear flushes, clears, goes local.
// - Reset flushes, clears masks, keeps remote.
// - Power-up clears all but the power flag and the flush, starts local.
// - Local on power, key, go-to-local, release.
// - Remote when listened with remote-enable; lockout.
// - Act on listed messages, ignore others.
module gsr_status_reporting (
  input wire logic clk,
  input wire logic reset_n,
  input wire gsr_pkg::gsr_cmd_t cmd,
  input wire logic [7:0] wrData,
  input wire gsr_pkg::gsr_msg_t busMsg,
  input wire logic ifcStrobe,
  input wire logic remoteEnable,
  input wire logic localKeyPress,
  input wire logic queueEmpty,
  input wire logic localBusError,
  input wire logic localBusTimeout,
  input wire logic serialPollRead,
  input wire logic gpibSelected,
  output logic [7:0] eventFlags,
  output logic [7:0] eventEnable,
  output logic [7:0] statusByte,
  output logic [7:0] pollByte,
  output logic srqOut,
  output logic flushQueues,
  output logic listenAddressed,
  output logic talkAddressed,
  output logic serialPollActive,
  output logic remoteState,
  output logic lockoutState,
  output gsr_pkg::gsr_keys_t keysAllowed
);
  logic [7:0] event_reg;
  logic [7:0] enable_reg;
  logic [7:0] sre_reg;
  logic rqs_reg;
  logic mssPrev_reg;
  logic flush_reg;
  logic [7:0] event_next;
  logic [7:0] stbRaw;
  logic master_summary_bit;
  logic esbExpect;
  logic devClear;
  logic clearAll;

  assign devClear = (busMsg == gsr_pkg::MSG_DCL) || (busMsg == gsr_pkg::MSG_SDC);
  assign clearAll = devClear || cmd.resetCmd;

  // Sets in the same cycle as a read-clear are kept, so no event is lost.
  always_comb
  begin
    event_next = event_reg;
    if (cmd.readEvents || cmd.clearStatus || clearAll)
    begin
      event_next = 8'h00;
    end
    if (cmd.execError)
    begin
      event_next[gsr_pkg::EVT_EXE] = 1'b1;
    end
    if (cmd.cmdError)
    begin
      event_next[gsr_pkg::EVT_CME] = 1'b1;
    end
    if (cmd.alarm)
    begin
      event_next[gsr_pkg::EVT_ALM] = 1'b1;
    end
    if (cmd.opComplete)
    begin
      event_next[gsr_pkg::EVT_OPC] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      event_reg <= gsr_pkg::EVT_RESET;
    end
    else
    begin
      event_reg <= event_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_reg <= gsr_pkg::MASK_RESET;
      sre_reg <= gsr_pkg::SRE_RESET;
    end
    else if (cmd.resetCmd)
    begin
      enable_reg <= gsr_pkg::MASK_RESET;
      sre_reg <= gsr_pkg::SRE_RESET;
    end
    else
    begin
      if (cmd.writeEnable)
      begin
        enable_reg <= wrData;
      end
      if (cmd.writeSre)
      begin
        sre_reg <= wrData;
      end
    end
  end

  always_comb
  begin
    stbRaw = 8'h00;
    stbRaw[gsr_pkg::STB_ESB] = |(event_reg & enable_reg);
    stbRaw[gsr_pkg::STB_MAV] = ~queueEmpty & ~flush_reg;
    stbRaw[gsr_pkg::STB_INTERNAL_BUS_ERROR_BIT] = localBusError;
    stbRaw[gsr_pkg::STB_TMO] = localBusTimeout;
  end

  assign master_summary_bit = |(stbRaw & sre_reg);

  // Request bit rises on a master summary edge; a new edge beats a poll clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rqs_reg <= 1'b0;
      mssPrev_reg <= 1'b0;
    end
    else
    begin
      mssPrev_reg <= master_summary_bit;
      if (master_summary_bit && !mssPrev_reg)
      begin
        rqs_reg <= 1'b1;
      end
      else if (!master_summary_bit || serialPollRead || cmd.clearStatus || clearAll)
      begin
        rqs_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flush_reg <= 1'b1;
    end
    else
    begin
      flush_reg <= clearAll;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      listenAddressed <= 1'b0;
      talkAddressed <= 1'b0;
      serialPollActive <= 1'b0;
    end
    else if (ifcStrobe || clearAll)
    begin
      listenAddressed <= 1'b0;
      talkAddressed <= 1'b0;
      serialPollActive <= 1'b0;
    end
    else
    begin
      case (busMsg)
        gsr_pkg::MSG_LISTEN: listenAddressed <= 1'b1;
        gsr_pkg::MSG_TALK: talkAddressed <= 1'b1;
        gsr_pkg::MSG_UNL: listenAddressed <= 1'b0;
        gsr_pkg::MSG_UNT: talkAddressed <= 1'b0;
        gsr_pkg::MSG_SPE: serialPollActive <= 1'b1;
        gsr_pkg::MSG_SPD: serialPollActive <= 1'b0;
        default: serialPollActive <= serialPollActive;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remoteState <= 1'b0;
      lockoutState <= 1'b0;
    end
    else if (devClear || !remoteEnable)
    begin
      remoteState <= 1'b0;
      lockoutState <= devClear ? 1'b0 : lockoutState & remoteEnable;
    end
    else
    begin
      if (busMsg == gsr_pkg::MSG_LISTEN)
      begin
        remoteState <= 1'b1;
      end
      else if ((busMsg == gsr_pkg::MSG_GTL && listenAddressed)
               || (localKeyPress && !lockoutState))
      begin
        remoteState <= 1'b0;
      end
      if (busMsg == gsr_pkg::MSG_LLO)
      begin
        lockoutState <= 1'b1;
      end
    end
  end

  assign keysAllowed.otherKeys = ~remoteState;
  assign keysAllowed.localKey = ~(remoteState & lockoutState);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eventFlags <= gsr_pkg::EVT_RESET;
      eventEnable <= gsr_pkg::MASK_RESET;
      statusByte <= 8'h00;
      pollByte <= 8'h00;
    end
    else
    begin
      if (cmd.readEvents)
      begin
        eventFlags <= event_reg;
      end
      else
      begin
        eventFlags <= event_next;
      end
      eventEnable <= enable_reg;
      statusByte <= stbRaw | {1'b0, master_summary_bit, 6'h00};
      pollByte <= stbRaw | {1'b0, rqs_reg, 6'h00};
    end
  end

  assign srqOut = rqs_reg & gpibSelected;
  assign flushQueues = flush_reg;

  assign esbExpect = |(event_reg & enable_reg);

  // Power-up leaves the event register with only the power flag set.
  a_pon_flag: assert property (@(posedge clk) $rose(reset_n) |-> event_reg == 8'h80)
    else $error("power flag not sole bit after reset");
  a_exe_set: assert property (@(posedge clk) disable iff (!reset_n)
    cmd.execError |=> event_reg[4])
    else $error("execution error not flagged");
  a_cme_set: assert property (@(posedge clk) disable iff (!reset_n)
    cmd.cmdError |=> event_reg[5])
    else $error("command error not flagged");
  a_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
    cmd.readEvents && !cmd.execError && !cmd.cmdError && !cmd.alarm && !cmd.opComplete
    |=> event_reg == 8'h00)
    else $error("event read did not clear");
  a_mask_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !cmd.writeEnable && !cmd.resetCmd |=> $stable(enable_reg))
    else $error("enable mask changed unasked");
  a_esb_sum: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 statusByte[5] == $past(esbExpect))
    else $error("event summary wrong");
  a_srq_gpib: assert property (@(posedge clk) disable iff (!reset_n)
    srqOut |-> gpibSelected && rqs_reg)
    else $error("request off the bus");
  a_poll_clear: assert property (@(posedge clk) disable iff (!reset_n)
    serialPollRead && !(master_summary_bit && !mssPrev_reg) |=> !rqs_reg)
    else $error("poll did not clear request");
  a_dcl_local: assert property (@(posedge clk) disable iff (!reset_n)
    busMsg == gsr_pkg::MSG_DCL |=> !remoteState && !lockoutState)
    else $error("device clear left remote");
  a_ifc_keep: assert property (@(posedge clk) disable iff (!reset_n)
    ifcStrobe && remoteEnable && busMsg == gsr_pkg::MSG_NONE && !localKeyPress
    |=> $stable(remoteState) && !listenAddressed)
    else $error("interface clear wrong");

  c_srq_raised: cover property (@(posedge clk) disable iff (!reset_n) $rose(srqOut));
  c_remote: cover property (@(posedge clk) disable iff (!reset_n) $rose(remoteState));
  c_lockout: cover property (@(posedge clk) disable iff (!reset_n) $rose(lockoutState));
  c_poll: cover property (@(posedge clk) disable iff (!reset_n) serialPollRead && rqs_reg);
endmodule

// ==== sim/gsr_ctl_model.sv ====
// Bus controller model that issues interface messages and polls.
`timescale 1ns/10ps
module gsr_ctl_model (
  input wire logic clk,
  output gsr_pkg::gsr_msg_t busMsg,
  output logic ifcStrobe,
  output logic remoteEnable,
  output logic serialPollRead
);
  initial
  begin
    busMsg = gsr_pkg::MSG_NONE;
    ifcStrobe = 1'b0;
    remoteEnable = 1'b0;
    serialPollRead = 1'b0;
  end
  // One bus message.
  // The line goes idle after one cycle, since each held cycle counts as a new message.
  task automatic send(input gsr_pkg::gsr_msg_t m);
    @(negedge clk);
    busMsg = m;
    @(negedge clk);
    busMsg = gsr_pkg::MSG_NONE;
  endtask
  task automatic ifc();
    @(negedge clk);
    ifcStrobe = 1'b1;
    @(negedge clk);
    ifcStrobe = 1'b0;
  endtask
  task automatic pollRead();
    @(negedge clk);
    serialPollRead = 1'b1;
    @(negedge clk);
    serialPollRead = 1'b0;
  endtask
  task automatic setRen(input logic v);
    @(negedge clk);
    remoteEnable = v;
  endtask
endmodule

// ==== sim/tb_gsr_status_reporting.sv ====
// Self-checking testbench of the status reporting block.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_gsr_status_reporting;
  localparam logic [8:0] cmdErr = 9'h100;
  localparam logic [8:0] exeErr = 9'h080;
  localparam logic [8:0] alarmOpc = 9'h060;
  localparam logic [8:0] clrSt = 9'h010;
  localparam logic [8:0] rstCmd = 9'h008;
  localparam logic [8:0] wrEn = 9'h004;
  localparam logic [8:0] wrSre = 9'h002;
  localparam logic [8:0] rdEv = 9'h001;
  logic clk, reset_n, localKeyPress, queueEmpty, localBusError, localBusTimeout, gpibSelected;
  logic ifcStrobe, remoteEnable, serialPollRead, srqOut, flushQueues;
  logic listenAddressed, talkAddressed, serialPollActive, remoteState, lockoutState;
  logic [7:0] wrData, eventFlags, eventEnable, statusByte, pollByte;
  gsr_pkg::gsr_cmd_t cmd;
  gsr_pkg::gsr_msg_t busMsg;
  gsr_pkg::gsr_keys_t keysAllowed;
  int n_mismatch = 0;
  int tests_run = 0;
  gsr_ctl_model i_gsr_ctl_model (.clk(clk), .busMsg(busMsg), .ifcStrobe(ifcStrobe),
    .remoteEnable(remoteEnable), .serialPollRead(serialPollRead));
  gsr_status_reporting i_gsr_status_reporting (.clk(clk), .reset_n(reset_n), .cmd(cmd),
    .wrData(wrData), .busMsg(busMsg), .ifcStrobe(ifcStrobe), .remoteEnable(remoteEnable),
    .localKeyPress(localKeyPress), .queueEmpty(queueEmpty), .localBusError(localBusError),
    .localBusTimeout(localBusTimeout), .serialPollRead(serialPollRead),
    .gpibSelected(gpibSelected), .eventFlags(eventFlags), .eventEnable(eventEnable),
    .statusByte(statusByte), .pollByte(pollByte), .srqOut(srqOut), .flushQueues(flushQueues),
    .listenAddressed(listenAddressed), .talkAddressed(talkAddressed),
    .serialPollActive(serialPollActive), .remoteState(remoteState),
    .lockoutState(lockoutState), .keysAllowed(keysAllowed));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic doCmd(input logic [8:0] c, input logic [7:0] d);
    @(negedge clk);
    cmd = gsr_pkg::gsr_cmd_t'(c);
    wrData = d;
    @(negedge clk);
    cmd = gsr_pkg::gsr_cmd_t'(9'h000);
  endtask
  task automatic keyPress();
    @(negedge clk);
    localKeyPress = 1'b1;
    wt(1);
    localKeyPress = 1'b0;
    wt(1);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic powerUp();
    reset_n = 1'b0;
    wt(8);
    `CHK("ev", 8'h80, eventFlags);
    `CHK("en", 8'h00, eventEnable);
    `CHK("st", 11'h001, {statusByte, remoteState, lockoutState, flushQueues});
    reset_n = 1'b1;
    wt(1);
    `CHK("fl", 1'b0, flushQueues);
  endtask
  task automatic tEvents();
    doCmd(rdEv, 8'h00);
    `CHK("ev", 8'h80, eventFlags);
    wt(1);
    `CHK("ev", 8'h00, eventFlags);
    doCmd(cmdErr, 8'h00);
    `CHK("ev", 8'h20, eventFlags);
    doCmd(exeErr, 8'h00);
    `CHK("ev", 8'h30, eventFlags);
  endtask
  task automatic tSummary();
    doCmd(wrEn, 8'h30);
    wt(1);
    `CHK("en", 8'h30, eventEnable);
    `CHK("sb", 8'h20, statusByte);
    doCmd(wrEn, 8'h08);
    wt(1);
    `CHK("sb", 8'h00, statusByte);
    doCmd(alarmOpc, 8'h00);
    wt(1);
    `CHK("sb", 8'h20, statusByte);
    doCmd(wrSre, 8'h20);
    wt(2);
    `CHK("sq", {statusByte, srqOut, pollByte[6]}, 10'h183);
    gpibSelected = 1'b0;
    wt(1);
    `CHK("srq", 1'b0, srqOut);
    gpibSelected = 1'b1;
    i_gsr_ctl_model.pollRead();
    wt(1);
    `CHK("pl", {pollByte[6], statusByte}, 9'h060);
    doCmd(clrSt, 8'h00);
    wt(1);
    `CHK("cl", {eventFlags, statusByte, srqOut, eventEnable}, 25'h000008);
  endtask
  task automatic tStatusBits();
    queueEmpty = 1'b0;
    localBusError = 1'b1;
    localBusTimeout = 1'b1;
    wt(3);
    `CHK("sb", 8'h13, statusByte);
    doCmd(wrSre, 8'h10);
    wt(2);
    `CHK("sb", {statusByte, srqOut}, 9'ha7);
    queueEmpty = 1'b1;
    localBusError = 1'b0;
    localBusTimeout = 1'b0;
    wt(3);
    `CHK("sb", {statusByte, srqOut}, 9'h000);
  endtask
  task automatic tRemote();
    gsr_pkg::gsr_msg_t ign [4] = '{gsr_pkg::MSG_GET, gsr_pkg::MSG_PPU, gsr_pkg::MSG_PPC,
      gsr_pkg::MSG_TCT};
    i_gsr_ctl_model.setRen(1'b1);
    i_gsr_ctl_model.send(gsr_pkg::MSG_LISTEN);
    wt(1);
    `CHK("rm", {listenAddressed, remoteState, keysAllowed}, 4'hd);
    foreach (ign[i])
    begin
      i_gsr_ctl_model.send(ign[i]);
      wt(1);
      `CHK("ig", {listenAddressed, remoteState, lockoutState, flushQueues}, 4'hc);
    end
    i_gsr_ctl_model.send(gsr_pkg::MSG_LLO);
    keyPress();
    `CHK("lo", {remoteState, lockoutState, keysAllowed}, 4'hc);
    doCmd(wrEn, 8'hff);
    i_gsr_ctl_model.ifc();
    wt(1);
    `CHK("ic", 11'h3ff, {listenAddressed, remoteState, lockoutState, eventEnable});
    doCmd(rstCmd, 8'h00);
    `CHK("fl", 1'b1, flushQueues);
    queueEmpty = 1'b0;
    wt(3);
    `CHK("rs", {remoteState, lockoutState, eventEnable, statusByte}, 18'h30010);
    queueEmpty = 1'b1;
    i_gsr_ctl_model.send(gsr_pkg::MSG_DCL);
    `CHK("fl", 1'b1, flushQueues);
    wt(1);
    `CHK("dc", {remoteState, lockoutState, keysAllowed}, 4'h3);
  endtask
  task automatic tLocal();
    gsr_pkg::gsr_msg_t seq [6] = '{gsr_pkg::MSG_LISTEN, gsr_pkg::MSG_UNL, gsr_pkg::MSG_TALK,
      gsr_pkg::MSG_UNT, gsr_pkg::MSG_SPE, gsr_pkg::MSG_SPD};
    logic [2:0] exp [6] = '{3'h4, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0};
    for (int k = 0; k < 4; k++)
    begin
      i_gsr_ctl_model.send(gsr_pkg::MSG_LISTEN);
      `CHK("lr", 1'b1, remoteState);
      if (k == 0) i_gsr_ctl_model.send(gsr_pkg::MSG_GTL);
      if (k == 1) keyPress();
      if (k == 2) i_gsr_ctl_model.setRen(1'b0);
      if (k == 3) i_gsr_ctl_model.send(gsr_pkg::MSG_SDC);
      wt(1);
      `CHK("lc", 1'b0, remoteState);
      i_gsr_ctl_model.setRen(1'b1);
    end
    foreach (seq[i])
    begin
      i_gsr_ctl_model.send(seq[i]);
      wt(1);
      `CHK("ad", {listenAddressed, talkAddressed, serialPollActive}, exp[i]);
    end
    doCmd(wrEn, 8'hff);
    i_gsr_ctl_model.send(gsr_pkg::MSG_LLO);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    cmd = gsr_pkg::gsr_cmd_t'(9'h000);
    wrData = 8'h00;
    localKeyPress = 1'b0;
    queueEmpty = 1'b1;
    localBusError = 1'b0;
    localBusTimeout = 1'b0;
    gpibSelected = 1'b1;
    powerUp();
    tEvents();
    tSummary();
    tStatusBits();
    tRemote();
    tLocal();
    powerUp();
    conclude();
  end
endmodule
